// *** hdl/prox_adc_input_select.v ***
// Proximity channel converter input selection and recovery timing.
// Assumes a sequencer that pulses start_ch with the channel number and
// waits for meas_go before integrating.
`timescale 1ns/1ps
`include "prox_input_consts.vh"

module prox_adc_input_select #(
  parameter INT_BASE_CYCLES = 2560
) (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Register port
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // Measurement sequencing
  input  wire       start,
  input  wire [1:0] start_ch,
  output reg        recovering,
  output reg        meas_go,
  output reg  [2:0] adc_source,
  output reg        led_enable,
  output reg        prox_detect,
  output reg        sel_invalid,
  output reg  [2:0] gain_out,
  output reg [15:0] integ_cycles
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0]  ch_sel [0:2];
  reg [7:0]  recovery_cfg;
  reg [7:0]  gain_cfg;
  reg [7:0]  misc_cfg;
  reg [20:0] rec_count;
  reg        busy;

  // Next values of the configuration registers
  reg [7:0]  next_ch_sel0;
  reg [7:0]  next_ch_sel1;
  reg [7:0]  next_ch_sel2;
  reg [7:0]  next_recovery_cfg;
  reg [7:0]  next_gain_cfg;
  reg [7:0]  next_misc_cfg;

  // Next values of the measurement state and outputs
  reg        next_busy;
  reg        next_recovering;
  reg        next_meas_go;
  reg [20:0] next_rec_count;
  reg [2:0]  next_adc_source;
  reg        next_led_enable;
  reg        next_prox_detect;
  reg        next_sel_invalid;
  reg [2:0]  next_gain_out;
  reg [15:0] next_integ_cycles;

  // ----------------------------------------
  // Decoded configuration fields
  // ----------------------------------------
  wire       normal_mode = misc_cfg[`MODE_BIT];
  wire [2:0] rec_code    = recovery_cfg[`REC_MSB:`REC_LSB];
  wire [2:0] gain        = gain_cfg[2:0];
  wire [7:0] status      = {6'h00, busy, recovering};

  // Base integration length cut to the output width on purpose
  localparam [15:0] INT_BASE = INT_BASE_CYCLES[15:0];

  // Codes valid in both modes
  function [3:0] decode_common;
    input [7:0] code;
    begin
      case (code)
        `SEL_LARGE_IR: decode_common = {1'b0, `SRC_LARGE_IR};
        `SEL_SMALL_IR: decode_common = {1'b0, `SRC_SMALL_IR};
        default:       decode_common = {1'b1, `SRC_NONE};
      endcase
    end
  endfunction

  // Codes added only in raw converter mode
  function [3:0] decode_raw;
    input [7:0] code;
    begin
      case (code)
        `SEL_VISIBLE: decode_raw = {1'b0, `SRC_VISIBLE};
        `SEL_NO_PD:   decode_raw = {1'b0, `SRC_NO_PD};
        `SEL_GND:     decode_raw = {1'b0, `SRC_GND};
        `SEL_TEMP:    decode_raw = {1'b0, `SRC_TEMP};
        `SEL_VDD:     decode_raw = {1'b0, `SRC_VDD};
        default:      decode_raw = decode_common(code);
      endcase
    end
  endfunction

  // Decode of one selector byte; same table for all channels
  // Raw-only codes in normal mode route nothing and flag invalid.
  function [3:0] decode;
    input [7:0] code;
    input       normal;
    begin
      if (normal) decode = decode_common(code);
      else decode = decode_raw(code);
    end
  endfunction

  // Recovery length in system cycles: the code picks 1, 7, 15 .. 511
  // converter clocks, each 50 ns scaled by 2^gain
  function [20:0] rec_cycles;
    input [2:0]  code;
    input [2:0]  g;
    reg   [9:0]  conv;
    reg   [31:0] prod;
    begin
      case (code)
        3'h0:    conv = 10'h001;
        3'h1:    conv = 10'h007;
        3'h2:    conv = 10'h00F;
        3'h3:    conv = 10'h01F;
        3'h4:    conv = 10'h03F;
        3'h5:    conv = 10'h07F;
        3'h6:    conv = 10'h0FF;
        default: conv = 10'h1FF;
      endcase
      // Longest case, 511 clocks at gain 7, needs 19 bits
      prod       = {22'h000000, conv} * `CONV_CLK_CYCLES;
      rec_cycles = prod[20:0] << g;
    end
  endfunction

  // Read data for one address; unmapped addresses show status
  function [7:0] read_mux;
    input [7:0] a;
    begin
      if (a == `OFF_CH1_SEL) read_mux = ch_sel[0];
      else if (a == `OFF_CH2_SEL) read_mux = ch_sel[1];
      else if (a == `OFF_CH3_SEL) read_mux = ch_sel[2];
      else if (a == `OFF_RECOVERY) read_mux = recovery_cfg;
      else if (a == `OFF_GAIN) read_mux = gain_cfg;
      else if (a == `OFF_MISC) read_mux = misc_cfg;
      else read_mux = status;
    end
  endfunction

  // Channel index 3 has no selector; its decode is never used
  wire [3:0] dec = decode(ch_sel[start_ch], normal_mode);

  // A start for index 3 or during a measurement is dropped, so the
  // host must wait for the go pulse before the next start.
  wire       accept = !busy && start && (start_ch != 2'h3);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Masks keep reserved recovery, gain and misc bits at zero whatever the host
  // writes; the channel selectors store the whole written byte unmasked.
  always @* begin
    next_ch_sel0      = ch_sel[0];
    next_ch_sel1      = ch_sel[1];
    next_ch_sel2      = ch_sel[2];
    next_recovery_cfg = recovery_cfg;
    next_gain_cfg     = gain_cfg;
    next_misc_cfg     = misc_cfg;
    if (wr) begin
      if (addr == `OFF_CH1_SEL) next_ch_sel0 = wdata;
      else if (addr == `OFF_CH2_SEL) next_ch_sel1 = wdata;
      else if (addr == `OFF_CH3_SEL) next_ch_sel2 = wdata;
      else if (addr == `OFF_RECOVERY) next_recovery_cfg = wdata & `RECOVERY_MASK;
      else if (addr == `OFF_GAIN) next_gain_cfg = wdata & `GAIN_MASK;
      else if (addr == `OFF_MISC) next_misc_cfg = wdata & `MISC_MASK;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ch_sel[0]    <= `RST_SEL;
      ch_sel[1]    <= `RST_SEL;
      ch_sel[2]    <= `RST_SEL;
      recovery_cfg <= `RST_RECOVERY;
      gain_cfg     <= `RST_GAIN;
      misc_cfg     <= `RST_MISC;
    end else begin
      ch_sel[0]    <= next_ch_sel0;
      ch_sel[1]    <= next_ch_sel1;
      ch_sel[2]    <= next_ch_sel2;
      recovery_cfg <= next_recovery_cfg;
      gain_cfg     <= next_gain_cfg;
      misc_cfg     <= next_misc_cfg;
    end
  end

  // ----------------------------------------
  // Register reads, data one cycle after strobe
  // ----------------------------------------
  // Read data stand for one cycle only; idle cycles show zero.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= read_mux(addr);
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Measurement start and recovery wait
  // ----------------------------------------
  // Settings are latched at start so a write mid-recovery cannot
  // change the routing of a measurement already under way.
  always @* begin
    next_busy         = busy;
    next_recovering   = recovering;
    next_meas_go      = 1'b0;
    next_rec_count    = rec_count;
    next_adc_source   = adc_source;
    next_led_enable   = led_enable;
    next_prox_detect  = prox_detect;
    next_sel_invalid  = sel_invalid;
    next_gain_out     = gain_out;
    next_integ_cycles = integ_cycles;
    if (accept) begin
      next_busy         = 1'b1;
      next_recovering   = 1'b1;
      // Loaded one short: the zero cycle is the last recovery cycle
      next_rec_count    = rec_cycles(rec_code, gain) - 21'h000001;
      next_adc_source   = dec[2:0];
      next_sel_invalid  = dec[3];
      next_led_enable   = normal_mode;
      next_prox_detect  = normal_mode;
      next_gain_out     = gain;
      next_integ_cycles = INT_BASE << gain;
    end else if (recovering) begin
      // Count down to zero, then one go pulse frees the sequencer
      if (rec_count == 21'h000000) begin
        next_recovering = 1'b0;
        next_meas_go    = 1'b1;
        next_busy       = 1'b0;
      end else begin
        next_rec_count = rec_count - 21'h000001;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy         <= 1'b0;
      recovering   <= 1'b0;
      meas_go      <= 1'b0;
      rec_count    <= 21'h000000;
      adc_source   <= `SRC_NONE;
      led_enable   <= 1'b0;
      prox_detect  <= 1'b0;
      sel_invalid  <= 1'b0;
      gain_out     <= 3'h0;
      integ_cycles <= 16'h0000;
    end else begin
      busy         <= next_busy;
      recovering   <= next_recovering;
      meas_go      <= next_meas_go;
      rec_count    <= next_rec_count;
      adc_source   <= next_adc_source;
      led_enable   <= next_led_enable;
      prox_detect  <= next_prox_detect;
      sel_invalid  <= next_sel_invalid;
      gain_out     <= next_gain_out;
      integ_cycles <= next_integ_cycles;
    end
  end

  // Gains above 5 are not blocked here; long recoveries and high LED
  // energy are the host's responsibility.

endmodule // prox_adc_input_select

// *** hdl/prox_input_consts.vh ***
// Constants for the proximity converter input selection block.
// Assumes byte-wide registers reached at their printed offsets.
`ifndef PROX_INPUT_CONSTS_VH
`define PROX_INPUT_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_CH1_SEL      8'h07
`define OFF_CH2_SEL      8'h08
`define OFF_CH3_SEL      8'h09
`define OFF_RECOVERY     8'h0A
`define OFF_GAIN         8'h0B
`define OFF_MISC         8'h0C

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_SEL          8'h03
`define RST_RECOVERY     8'h70
`define RST_GAIN         8'h00
`define RST_MISC         8'h04

// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define REC_MSB          6
`define REC_LSB          4
`define RECOVERY_MASK    8'h70
`define GAIN_MASK        8'h07
`define MODE_BIT         2
`define MISC_MASK        8'h04

// ----------------------------------------
// Input selection codes
// ----------------------------------------
`define SEL_SMALL_IR     8'h00
`define SEL_VISIBLE      8'h02
`define SEL_LARGE_IR     8'h03
`define SEL_NO_PD        8'h06
`define SEL_GND          8'h25
`define SEL_TEMP         8'h65
`define SEL_VDD          8'h75

// Routed converter sources
`define SRC_NONE         3'h0
`define SRC_SMALL_IR     3'h1
`define SRC_LARGE_IR     3'h2
`define SRC_VISIBLE      3'h3
`define SRC_NO_PD        3'h4
`define SRC_GND          3'h5
`define SRC_TEMP         3'h6
`define SRC_VDD          3'h7

// ----------------------------------------
// Timing: one converter clock is 50 ns at gain 0
// ----------------------------------------
`define CONV_CLK_NS      50
`define SYS_CLK_NS       10
`define CONV_CLK_CYCLES  (`CONV_CLK_NS / `SYS_CLK_NS)

`endif

// *** bench/prox_adc_input_select_asserts.sv ***
// Port-level checks for the proximity input selection block.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module prox_adc_input_select_asserts #(
  parameter INT_BASE_CYCLES = 2560
) (
  // Clock and reset
  input wire        clk,
  input wire        rst_n,
  // Register port
  input wire [7:0]  addr,
  input wire [7:0]  wdata,
  input wire        wr,
  input wire        rd,
  input wire [7:0]  rdata,
  // Measurement sequencing
  input wire        start,
  input wire [1:0]  start_ch,
  input wire        recovering,
  input wire        meas_go,
  input wire [2:0]  adc_source,
  input wire        led_enable,
  input wire        prox_detect,
  input wire        sel_invalid,
  input wire [2:0]  gain_out,
  input wire [15:0] integ_cycles
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shortest recovery is one converter clock of five system cycles
  sequence s_rec_run;
    recovering [*5];
  endsequence
  a_led_detect_tie: assert property (led_enable == prox_detect)
    else $error("led drive and detection disagree");
  a_raw_src_noled: assert property (adc_source >= 3'h3 |-> !led_enable)
    else $error("raw-only source with led drive on");
  a_invalid_none: assert property (sel_invalid |-> adc_source == 3'h0)
    else $error("invalid code still routes a source");
  a_rec_min: assert property ($rose(recovering) |-> s_rec_run)
    else $error("recovery shorter than one converter clock");
  a_go_after_rec: assert property (meas_go |-> $past(recovering) && !recovering)
    else $error("go without preceding recovery");
  a_go_single: assert property (meas_go |=> !meas_go)
    else $error("go longer than one cycle");
  a_integ_scale: assert property (meas_go |-> integ_cycles == 16'(INT_BASE_CYCLES << gain_out))
    else $error("integration time not scaled by gain");
  a_rec_reserved: assert property (rd && addr == 8'h0A |=> rdata[7] == 1'b0 && rdata[3:0] == 4'h0)
    else $error("reserved recovery bits read nonzero");
endmodule // prox_adc_input_select_asserts
bind prox_adc_input_select prox_adc_input_select_asserts #(.INT_BASE_CYCLES(INT_BASE_CYCLES)) u_chk (.*);

// *** bench/tb.sv ***
// Self-checking bench for the proximity input selection block.
// Drives register port and start strobe directly; short integration base.
`timescale 1ns/1ps
module tb;
  reg         clk = 0, rst_n = 0, wr = 0, rd = 0, start = 0;
  reg  [7:0]  addr = 0, wdata = 0;
  reg  [1:0]  start_ch = 0;
  wire [7:0]  rdata;
  wire        recovering, meas_go, led_enable, prox_detect, sel_invalid;
  wire [2:0]  adc_source, gain_out;
  wire [15:0] integ_cycles;
  integer     fail_count = 0, num_checks = 0, k;
  reg  [7:0]  codes [0:6] = '{8'h00, 8'h02, 8'h03, 8'h06, 8'h25, 8'h65, 8'h75};
  reg  [2:0]  srcs [0:6] = '{3'h1, 3'h3, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
  always #5 clk = ~clk;
  prox_adc_input_select #(.INT_BASE_CYCLES(16)) u_prox_adc_input_select (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .start(start), .start_ch(start_ch), .recovering(recovering), .meas_go(meas_go),
    .adc_source(adc_source), .led_enable(led_enable), .prox_detect(prox_detect),
    .sel_invalid(sel_invalid), .gain_out(gain_out), .integ_cycles(integ_cycles));
  task chk(input [15:0] seen, input [15:0] exp, input string what);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wreg(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      wr <= 1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 0;
    end
  endtask
  task rreg(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      rd <= 1;
      addr <= a;
      @(posedge clk);
      rd <= 0;
      @(negedge clk);
      chk({8'h00, rdata}, {8'h00, exp}, "rdata");
    end
  endtask
  // Counts recovery cycles up to the go pulse, then checks the routing
  task meas(input [1:0] ch, input [2:0] src, input led, input [15:0] r);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      start <= 1;
      start_ch <= ch;
      @(posedge clk);
      start <= 0;
      @(negedge clk);
      while (meas_go !== 1'b1 && n < 20000) begin
        if (recovering === 1'b1) n = n + 1;
        @(negedge clk);
      end
      chk(n[15:0], r, "recovery");
      chk({13'h0, adc_source}, {13'h0, src}, "source");
      chk({14'h0, led_enable, prox_detect}, {14'h0, led, led}, "led");
      chk({15'h0, sel_invalid}, {15'h0, src == 3'h0}, "invalid");
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #200000;
    fail_count = fail_count + 1;
    summarize;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1;
    for (k = 7; k < 11; k = k + 1)
      rreg(k[7:0], k == 10 ? 8'h70 : 8'h03);
    rreg(8'h0C, 8'h04);
    rreg(8'h20, 8'h00);
    wreg(8'h0A, 8'h0F);
    rreg(8'h0A, 8'h00);
    for (k = 0; k < 3; k = k + 1) begin
      wreg(8'h07 + k[7:0], 8'h00);
      meas(k[1:0], 3'h1, 1'b1, 16'd5);
      wreg(8'h07 + k[7:0], 8'h02);
      meas(k[1:0], 3'h0, 1'b1, 16'd5);
    end
    wreg(8'h0C, 8'h00);
    for (k = 0; k < 7; k = k + 1) begin
      wreg(8'h07 + {6'h00, k[1:0] % 2'h3}, codes[k]);
      meas(k[1:0] % 2'h3, srcs[k], 1'b0, 16'd5);
    end
    wreg(8'h0C, 8'h04);
    wreg(8'h07, 8'h03);
    for (k = 0; k < 8; k = k + 1) begin
      wreg(8'h0A, {1'b0, k[2:0], 4'h0});
      meas(2'h0, 3'h2, 1'b1, k == 0 ? 16'd5 : 16'(((1 << (k + 2)) - 1) * 5));
    end
    wreg(8'h0B, 8'h02);
    wreg(8'h0A, 8'h10);
    meas(2'h0, 3'h2, 1'b1, 16'd140);
    chk({13'h0, gain_out}, 16'h0002, "gain");
    chk(integ_cycles, 16'h0040, "integration");
    rreg(8'h0B, 8'h02);
    wreg(8'h0A, 8'h50);
    meas(2'h0, 3'h2, 1'b1, 16'd2540);
    summarize;
  end
endmodule // tb
